// file: hdl/mdp_pkg.sv
// constants, commands and state type of the mobile ddr pattern memory port
// assumes a 200 MHz system clock; the memory clock is that clock divided by two
package mdp_pkg;
   // clocking
   localparam int SYS_CK_NS = 5;
   localparam int MEM_CK_NS = 2 * SYS_CK_NS;
   localparam int MEM_CK_NOMINAL_MHZ = 166;
   // geometry
   localparam int DQ_W = 16;
   localparam int BA_W = 2;
   localparam int ADDR_W = 13;
   localparam int ROW_W = 12;
   localparam int COL_W = 9;
   localparam int BURST_LEN = 4;
   localparam int DATA_W = DQ_W * BURST_LEN;
   localparam int MASK_W = 2 * BURST_LEN;
   localparam int AP_BIT = 10;
   // timing in memory clocks
   localparam int CAS_LAT_CK = 3;
   localparam int T_RCD_CK = 3;
   localparam int T_RP_CK = 3;
   localparam int T_MRD_CK = 2;
   localparam int T_WR_NS = 15;
   localparam int T_WR_CK = (T_WR_NS + MEM_CK_NS - 1) / MEM_CK_NS;
   localparam int T_RFC_NS = 72;
   localparam int T_RFC_CK = (T_RFC_NS + MEM_CK_NS - 1) / MEM_CK_NS;
   localparam int REFRESH_MS = 64;
   localparam int REFRESH_ROWS = 4096;
   localparam int REF_INT_CK = REFRESH_MS * 1000000 / REFRESH_ROWS / MEM_CK_NS;
   localparam int POWERUP_US = 200;
   localparam int POWERUP_CK = POWERUP_US * 1000 / MEM_CK_NS;
   localparam int WR_DONE_CK = BURST_LEN / 2 + 1 + T_WR_CK + T_RP_CK;
   // timing in system clocks
   localparam int RD_TIMEOUT_CYC = 64;
   localparam logic [3:0] WPH_PRE = 4'h2;
   localparam logic [3:0] WPH_FIRST = 4'h3;
   localparam logic [3:0] WPH_LAST = 4'h6;
   localparam logic [3:0] WPH_END = 4'h7;
   // mode registers: burst 4, cas latency 3
   localparam logic [12:0] MODE_REG = 13'h0032;
   localparam logic [12:0] EXT_MODE_REG = 13'h0000;
   localparam logic [1:0] EMR_BA = 2'h2;
   // commands {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_RD = 4'h5;
   localparam logic [3:0] CMD_WR = 4'h4;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_MRS = 4'h0;

   typedef enum logic [3:0] {
      ST_POWERUP, ST_INIT_PRE, ST_INIT_REF1, ST_INIT_REF2, ST_INIT_MRS, ST_INIT_EMRS,
      ST_IDLE, ST_RW, ST_RDATA, ST_WAIT
   } mdp_state_type;
endpackage : mdp_pkg

// file: hdl/mdp_sync.sv
// two flip-flop synchroniser for a group of pins
// assumes the inputs change independently of clk_i
`timescale 1ns/1ps
`default_nettype none
module mdp_sync #(
   parameter int W = 18
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // pins in, synchronised out
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } mdp_sync_type;

   mdp_sync_type st;
   mdp_sync_type next_st;

   always_comb begin
      next_st.s1 = d_i;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q_o = st.s2;
endmodule : mdp_sync
`default_nettype wire

// file: hdl/mdp_mem_port.sv
// mobile ddr sdram port: init, refresh, burst-4 pattern writes and reads
// assumes one x16 device point to point; pins resolved by the bench from the enables
`timescale 1ns/1ps
`default_nettype none
module mdp_mem_port #(
   parameter int POWERUP_CK = mdp_pkg::POWERUP_CK
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // pattern requests
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire logic req_write_i,
   input wire logic [mdp_pkg::BA_W-1:0] req_bank_i,
   input wire logic [mdp_pkg::ROW_W-1:0] req_row_i,
   input wire logic [mdp_pkg::COL_W-1:0] req_col_i,
   input wire logic [mdp_pkg::DATA_W-1:0] req_wdata_i,
   input wire logic [mdp_pkg::MASK_W-1:0] req_wmask_i,
   // read answers and status
   output logic rd_valid_o,
   output logic rd_err_o,
   output logic [mdp_pkg::DATA_W-1:0] rd_data_o,
   output logic init_done_o,
   // memory clock and command
   output logic mem_ck_p_o,
   output logic mem_ck_n_o,
   output logic mem_cke_o,
   output logic mem_cs_n_o,
   output logic mem_ras_n_o,
   output logic mem_cas_n_o,
   output logic mem_we_n_o,
   output logic [mdp_pkg::BA_W-1:0] mem_ba_o,
   output logic [mdp_pkg::ADDR_W-1:0] mem_a_o,
   // memory data, strobes and masks
   input wire logic [mdp_pkg::DQ_W-1:0] mem_dq_i,
   output logic [mdp_pkg::DQ_W-1:0] mem_dq_o,
   output logic mem_dq_oe_o,
   input wire logic sdram_strobe_lo_i,
   output logic sdram_strobe_lo_o,
   output logic sdram_strobe_lo_oe_o,
   input wire logic sdram_strobe_hi_i,
   output logic sdram_strobe_hi_o,
   output logic sdram_strobe_hi_oe_o,
   output logic sdram_mask_lo_o,
   output logic sdram_mask_hi_o
);
   typedef struct packed {
      mdp_pkg::mdp_state_type state;
      mdp_pkg::mdp_state_type ret;
      logic [15:0] cnt;
      logic [10:0] ref_cnt;
      logic ref_pend;
      logic [12:0] ref_age;
      logic ck_p;
      logic ck_n;
      logic cke;
      logic [3:0] cmd;
      logic [1:0] ba;
      logic [12:0] a;
      logic wr;
      logic [1:0] bank;
      logic [11:0] row;
      logic [8:0] col;
      logic [63:0] wdata;
      logic [7:0] wmask;
      logic [3:0] wph;
      logic [15:0] dq;
      logic dq_oe;
      logic dqs;
      logic dqs_oe;
      logic [1:0] dm;
      logic dqs_prev;
      logic [2:0] rcnt;
      logic [6:0] rto;
      logic [63:0] rdata;
      logic rd_valid;
      logic rd_err;
      logic ready;
      logic init_done;
   } mdp_ctl_type;

   mdp_ctl_type st;
   mdp_ctl_type next_st;
   logic cmd_en;
   logic [1:0] widx;
   logic [17:0] pins_s;

   // pins pass two flip-flops before any use
   mdp_sync #(.W(18)) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({sdram_strobe_hi_i, sdram_strobe_lo_i, mem_dq_i}),
      .q_o(pins_s)
   );

   function automatic mdp_ctl_type go_wait(input mdp_ctl_type s, input int cycles,
                                           input mdp_pkg::mdp_state_type r);
      mdp_ctl_type t;
      t = s;
      t.state = mdp_pkg::ST_WAIT;
      t.cnt = 16'(cycles - 1);
      t.ret = r;
      return t;
   endfunction : go_wait

   // commands change only where the memory clock falls
   assign cmd_en = st.ck_p;

   always_comb begin
      next_st = st;
      widx = 2'h0;
      next_st.ck_p = ~st.ck_p;
      next_st.ck_n = st.ck_p;
      next_st.rd_valid = 1'b0;
      next_st.rd_err = 1'b0;
      next_st.dqs_prev = pins_s[16];
      if (st.wph != 4'h0) begin
         next_st.wph = (st.wph == mdp_pkg::WPH_END) ? 4'h0 : st.wph + 4'h1;
      end
      if (st.cmd == mdp_pkg::CMD_REF && !st.ck_p) begin
         next_st.ref_age = 13'h0;
      end else if (st.ref_age != 13'h1fff) begin
         next_st.ref_age = st.ref_age + 13'h1;
      end
      // read capture on each edge of the lower lane strobe
      if (st.state == mdp_pkg::ST_RDATA) begin
         next_st.rto = st.rto + 7'h1;
         if (pins_s[16] != st.dqs_prev && st.rcnt != 3'h4) begin
            next_st.rdata[{st.rcnt[1:0], 4'h0} +: 16] = pins_s[15:0];
            next_st.rcnt = st.rcnt + 3'h1;
         end
         if (next_st.rcnt == 3'h4 || st.rto == 7'(mdp_pkg::RD_TIMEOUT_CYC - 1)) begin
            next_st.rd_valid = 1'b1;
            next_st.rd_err = (next_st.rcnt != 3'h4);
            next_st = go_wait(next_st, mdp_pkg::T_RP_CK, mdp_pkg::ST_IDLE);
         end
      end
      if (cmd_en) begin
         next_st.cmd = mdp_pkg::CMD_NOP;
         // refresh timer, runs from the last init refresh; set wins over the clear below
         if (st.init_done && st.ref_cnt == 11'h0) begin
            next_st.ref_cnt = 11'(mdp_pkg::REF_INT_CK - 1);
         end else if (st.ref_cnt != 11'h0) begin
            next_st.ref_cnt = st.ref_cnt - 11'h1;
         end
         unique case (st.state)
            mdp_pkg::ST_POWERUP: begin
               if (st.cnt == 16'h0) begin
                  next_st.cke = 1'b1;
                  next_st.state = mdp_pkg::ST_INIT_PRE;
               end else begin
                  next_st.cnt = st.cnt - 16'h1;
               end
            end
            mdp_pkg::ST_INIT_PRE: begin
               next_st.cmd = mdp_pkg::CMD_PRE;
               next_st.a = 13'h0;
               next_st.a[mdp_pkg::AP_BIT] = 1'b1;
               next_st = go_wait(next_st, mdp_pkg::T_RP_CK, mdp_pkg::ST_INIT_REF1);
            end
            mdp_pkg::ST_INIT_REF1: begin
               next_st.cmd = mdp_pkg::CMD_REF;
               next_st = go_wait(next_st, mdp_pkg::T_RFC_CK, mdp_pkg::ST_INIT_REF2);
            end
            mdp_pkg::ST_INIT_REF2: begin
               next_st.cmd = mdp_pkg::CMD_REF;
               next_st.ref_cnt = 11'(mdp_pkg::REF_INT_CK - 2);
               next_st = go_wait(next_st, mdp_pkg::T_RFC_CK, mdp_pkg::ST_INIT_MRS);
            end
            mdp_pkg::ST_INIT_MRS: begin
               next_st.cmd = mdp_pkg::CMD_MRS;
               next_st.ba = 2'h0;
               next_st.a = mdp_pkg::MODE_REG;
               next_st = go_wait(next_st, mdp_pkg::T_MRD_CK, mdp_pkg::ST_INIT_EMRS);
            end
            mdp_pkg::ST_INIT_EMRS: begin
               next_st.cmd = mdp_pkg::CMD_MRS;
               next_st.ba = mdp_pkg::EMR_BA;
               next_st.a = mdp_pkg::EXT_MODE_REG;
               next_st.init_done = 1'b1;
               next_st = go_wait(next_st, mdp_pkg::T_MRD_CK, mdp_pkg::ST_IDLE);
            end
            mdp_pkg::ST_IDLE: begin
               if (st.ref_pend) begin
                  next_st.cmd = mdp_pkg::CMD_REF;
                  next_st.ref_pend = 1'b0;
                  next_st = go_wait(next_st, mdp_pkg::T_RFC_CK, mdp_pkg::ST_IDLE);
               end else if (req_valid_i && st.ready) begin
                  next_st.wr = req_write_i;
                  next_st.bank = req_bank_i;
                  next_st.row = req_row_i;
                  next_st.col = {req_col_i[8:2], 2'h0};
                  next_st.wdata = req_wdata_i;
                  next_st.wmask = req_wmask_i;
                  next_st.cmd = mdp_pkg::CMD_ACT;
                  next_st.ba = req_bank_i;
                  next_st.a = {1'b0, req_row_i};
                  next_st = go_wait(next_st, mdp_pkg::T_RCD_CK, mdp_pkg::ST_RW);
               end
            end
            mdp_pkg::ST_RW: begin
               next_st.ba = st.bank;
               next_st.a = 13'h0;
               next_st.a[mdp_pkg::AP_BIT] = 1'b1;
               next_st.a[mdp_pkg::COL_W-1:0] = st.col;
               if (st.wr) begin
                  next_st.cmd = mdp_pkg::CMD_WR;
                  next_st.wph = 4'h1;
                  next_st = go_wait(next_st, mdp_pkg::WR_DONE_CK, mdp_pkg::ST_IDLE);
               end else begin
                  next_st.cmd = mdp_pkg::CMD_RD;
                  next_st.rcnt = 3'h0;
                  next_st.rto = 7'h0;
                  next_st.state = mdp_pkg::ST_RDATA;
               end
            end
            mdp_pkg::ST_RDATA: begin
            end
            mdp_pkg::ST_WAIT: begin
               if (st.cnt == 16'h0) begin
                  next_st.state = st.ret;
               end else begin
                  next_st.cnt = st.cnt - 16'h1;
               end
            end
         endcase
         if (st.init_done && st.ref_cnt == 11'h0) begin
            next_st.ref_pend = 1'b1;
         end
      end
      // write burst: strobe preamble, four words, postamble
      next_st.dqs_oe = next_st.wph >= mdp_pkg::WPH_PRE && next_st.wph <= mdp_pkg::WPH_END;
      next_st.dqs = next_st.wph == mdp_pkg::WPH_FIRST || next_st.wph == 4'h5;
      next_st.dq_oe = next_st.wph >= mdp_pkg::WPH_FIRST && next_st.wph <= mdp_pkg::WPH_LAST;
      next_st.dq = 16'h0;
      next_st.dm = 2'h0;
      if (next_st.dq_oe) begin
         widx = 2'(next_st.wph - mdp_pkg::WPH_FIRST);
         next_st.dq = next_st.wdata[{widx, 4'h0} +: 16];
         next_st.dm = next_st.wmask[{widx, 1'b0} +: 2];
      end
      next_st.ready = next_st.state == mdp_pkg::ST_IDLE && !next_st.ref_pend &&
                      next_st.ck_p && next_st.init_done;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '0;
         st.ck_n <= 1'b1;
         st.cmd <= mdp_pkg::CMD_NOP;
         st.cnt <= 16'(POWERUP_CK);
      end else begin
         st <= next_st;
      end
   end

   assign req_ready_o = st.ready;
   assign rd_valid_o = st.rd_valid;
   assign rd_err_o = st.rd_err;
   assign rd_data_o = st.rdata;
   assign init_done_o = st.init_done;
   assign mem_ck_p_o = st.ck_p;
   assign mem_ck_n_o = st.ck_n;
   assign mem_cke_o = st.cke;
   assign {mem_cs_n_o, mem_ras_n_o, mem_cas_n_o, mem_we_n_o} = st.cmd;
   assign mem_ba_o = st.ba;
   assign mem_a_o = st.a;
   assign mem_dq_o = st.dq;
   assign mem_dq_oe_o = st.dq_oe;
   assign sdram_strobe_lo_o = st.dqs;
   assign sdram_strobe_lo_oe_o = st.dqs_oe;
   assign sdram_strobe_hi_o = st.dqs;
   assign sdram_strobe_hi_oe_o = st.dqs_oe;
   assign sdram_mask_lo_o = st.dm[0];
   assign sdram_mask_hi_o = st.dm[1];

   // checks
   localparam int REF_AGE_MAX = 2 * (mdp_pkg::REF_INT_CK + mdp_pkg::T_RFC_CK + 64);
   logic act_now;
   logic pre_now;
   logic wr_now;
   logic rd_now;
   assign act_now = !st.ck_p && st.cmd == mdp_pkg::CMD_ACT;
   assign pre_now = !st.ck_p && st.cmd == mdp_pkg::CMD_PRE;
   assign wr_now = !st.ck_p && st.cmd == mdp_pkg::CMD_WR;
   assign rd_now = !st.ck_p && st.cmd == mdp_pkg::CMD_RD;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_ck_pair: assert property (mem_ck_n_o == !mem_ck_p_o)
      else $error("memory clock legs not complementary");
   chk_ck_toggle: assert property (!$past(rst_i) |-> mem_ck_p_o != $past(mem_ck_p_o))
      else $error("memory clock stopped");
   chk_row_top_low: assert property (act_now |-> mem_a_o[12] == 1'b0)
      else $error("unused row bit driven high");
   chk_rcd_gap: assert property (act_now |-> ##1 (st.cmd != mdp_pkg::CMD_RD &&
                                 st.cmd != mdp_pkg::CMD_WR)[*5])
      else $error("column access too soon after activate");
   chk_rp_gap: assert property (pre_now |-> ##1 (st.cmd != mdp_pkg::CMD_ACT)[*5])
      else $error("activate too soon after precharge");
   chk_wr_strobe: assert property (wr_now |-> ##1 (st.dqs_oe && !st.dqs) ##1 st.dqs
                                   ##1 !st.dqs ##1 st.dqs ##1 !st.dqs ##1 (st.dqs_oe && !st.dqs)
                                   ##1 !st.dqs_oe)
      else $error("write strobe sequence wrong");
   chk_wr_mask: assert property (wr_now |-> ##2 (st.dm == st.wmask[1:0] &&
                                 st.dq == st.wdata[15:0]) ##1 (st.dm == st.wmask[3:2]))
      else $error("write mask or data out of step");
   chk_ref_prio: assert property (cmd_en && st.state == mdp_pkg::ST_IDLE &&
                                  st.ref_pend |=> st.cmd == mdp_pkg::CMD_REF)
      else $error("refresh not issued first");
   chk_ref_bound: assert property (st.init_done |-> st.ref_age < REF_AGE_MAX)
      else $error("refresh interval exceeded");
   chk_rd_answer: assert property (rd_now |-> ##[1:80] rd_valid_o)
      else $error("read burst never answered");

   cov_write: cover property (wr_now);
   cov_read_ok: cover property (rd_valid_o && !rd_err_o);
   cov_refresh: cover property (st.init_done && !st.ck_p && st.cmd == mdp_pkg::CMD_REF);
   cov_init: cover property ($rose(init_done_o));
endmodule : mdp_mem_port
`default_nettype wire

// file: tb/mdp_sdram_model.sv
// partner model: one x16 mobile ddr sdram, four banks, burst 4
// assumes the bench resolves shared pins; commands taken on rising ck_p
`timescale 1ns/1ps
`default_nettype none
module mdp_sdram_model (
   // controller side
   input wire logic clk_i,
   input wire logic ck_p_i,
   input wire logic [3:0] cmd_i,
   input wire logic [1:0] ba_i,
   input wire logic [12:0] a_i,
   input wire logic [15:0] dq_i,
   input wire logic dq_oe_i,
   input wire logic [1:0] mask_i,
   // answer speed and silence
   input wire logic slow_i,
   input wire logic mute_i,
   // memory drive
   output logic [15:0] dq_o,
   output logic strobe_o,
   output logic strobe_oe_o,
   // observations
   output logic [12:0] mode_o,
   output int ref_cnt_o,
   output int ref_gap_o,
   output logic timing_bad_o
);
   logic [63:0] mem [logic [22:0]];
   logic [11:0] row [4];
   logic [22:0] key;
   logic [63:0] buf_w;
   logic [63:0] buf_r;
   int wcnt = 0;
   realtime t_act = 0;
   realtime t_ref = 0;
   event rd_ev;
   initial begin
      dq_o = 16'h0000;
      strobe_o = 1'b0;
      strobe_oe_o = 1'b0;
      mode_o = 13'h0000;
      ref_cnt_o = 0;
      ref_gap_o = 0;
      timing_bad_o = 1'b0;
   end
   always @(posedge ck_p_i) begin
      case (cmd_i)
         mdp_pkg::CMD_ACT: begin
            row[ba_i] = a_i[11:0];
            t_act = $realtime;
            if (a_i[12] !== 1'b0) timing_bad_o = 1'b1;
         end
         mdp_pkg::CMD_RD, mdp_pkg::CMD_WR: begin
            key = {ba_i, row[ba_i], a_i[8:0]};
            if ($realtime - t_act < 3 * mdp_pkg::MEM_CK_NS) timing_bad_o = 1'b1;
            if (cmd_i == mdp_pkg::CMD_RD) ->rd_ev;
         end
         mdp_pkg::CMD_REF: begin
            if (ref_cnt_o > 0 && $realtime - t_ref > ref_gap_o) begin
               ref_gap_o = int'($realtime - t_ref);
            end
            t_ref = $realtime;
            ref_cnt_o++;
         end
         mdp_pkg::CMD_MRS: if (ba_i == 2'h0) mode_o = a_i;
         default: ;
      endcase
   end
   // write words land one per clock while data is driven
   always @(negedge clk_i) begin
      if (dq_oe_i) begin
         if (wcnt == 0) buf_w = mem.exists(key) ? mem[key] : 64'h0;
         if (!mask_i[0]) buf_w[16*wcnt +: 8] = dq_i[7:0];
         if (!mask_i[1]) buf_w[16*wcnt+8 +: 8] = dq_i[15:8];
         mem[key] = buf_w;
         wcnt++;
      end else begin
         wcnt = 0;
      end
   end
   // read burst: preamble, four strobe edges, released lines go inverse
   // pins change on falling clk edges, clear of the controller's sampling edge
   always @(rd_ev) begin
      if (!mute_i) begin
         buf_r = mem.exists(key) ? mem[key] : 64'h0;
         #(2 * mdp_pkg::MEM_CK_NS + mdp_pkg::SYS_CK_NS / 2.0);
         strobe_oe_o = 1'b1;
         strobe_o = 1'b0;
         #(mdp_pkg::MEM_CK_NS);
         for (int k = 0; k < 4; k++) begin
            strobe_o = ~strobe_o;
            dq_o = buf_r[16*k +: 16];
            #(slow_i ? 10 : 5);
         end
         dq_o = ~dq_o;
         #(mdp_pkg::SYS_CK_NS);
         strobe_oe_o = 1'b0;
      end
   end
endmodule : mdp_sdram_model
`default_nettype wire

// file: tb/mdp_mem_port_tb.sv
// self-checking bench for the mobile ddr pattern memory port
// assumes the sdram partner model and a 200 MHz system clock
`timescale 1ns/1ps
`default_nettype none
module mdp_mem_port_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic valid = 1'b0;
   logic wr = 1'b0;
   logic [1:0] bank = 2'h0;
   logic [11:0] row = 12'h000;
   logic [8:0] col = 9'h000;
   logic [63:0] wdata = 64'h0;
   logic [7:0] wmask = 8'h00;
   logic slow = 1'b0;
   logic mute = 1'b0;
   logic ready, rd_valid, rd_err, init_done, ck_p, ck_n, cke, cs_n, ras_n, cas_n, we_n;
   logic dq_oe, lo_o, lo_oe, hi_o, hi_oe, lo_i, hi_i, m_lo, m_hi, m_s, m_soe, timing_bad;
   logic [63:0] rd_data;
   logic [1:0] ba;
   logic [12:0] a, mode;
   logic [15:0] dq_o, dq_i, m_dq;
   logic wire_bad = 1'b0;
   int ref_cnt, ref_gap;
   int err_count = 0;
   int checks_done = 0;
   assign dq_i = dq_oe ? dq_o : m_dq;
   assign lo_i = lo_oe ? lo_o : (m_soe ? m_s : 1'b0);
   assign hi_i = hi_oe ? hi_o : (m_soe ? m_s : 1'b0);
   always #2.5 clk_i = ~clk_i;
   mdp_mem_port #(.POWERUP_CK(20)) DUT (
      .clk_i(clk_i), .rst_i(rst_i), .req_valid_i(valid), .req_ready_o(ready),
      .req_write_i(wr), .req_bank_i(bank), .req_row_i(row), .req_col_i(col),
      .req_wdata_i(wdata), .req_wmask_i(wmask), .rd_valid_o(rd_valid), .rd_err_o(rd_err),
      .rd_data_o(rd_data), .init_done_o(init_done), .mem_ck_p_o(ck_p), .mem_ck_n_o(ck_n),
      .mem_cke_o(cke), .mem_cs_n_o(cs_n), .mem_ras_n_o(ras_n), .mem_cas_n_o(cas_n),
      .mem_we_n_o(we_n), .mem_ba_o(ba), .mem_a_o(a), .mem_dq_i(dq_i), .mem_dq_o(dq_o),
      .mem_dq_oe_o(dq_oe), .sdram_strobe_lo_i(lo_i), .sdram_strobe_lo_o(lo_o),
      .sdram_strobe_lo_oe_o(lo_oe), .sdram_strobe_hi_i(hi_i), .sdram_strobe_hi_o(hi_o),
      .sdram_strobe_hi_oe_o(hi_oe), .sdram_mask_lo_o(m_lo), .sdram_mask_hi_o(m_hi));
   mdp_sdram_model mem (
      .clk_i(clk_i), .ck_p_i(ck_p), .cmd_i({cs_n, ras_n, cas_n, we_n}), .ba_i(ba), .a_i(a),
      .dq_i(dq_i), .dq_oe_i(dq_oe), .mask_i({m_hi, m_lo}), .slow_i(slow), .mute_i(mute),
      .dq_o(m_dq), .strobe_o(m_s), .strobe_oe_o(m_soe), .mode_o(mode), .ref_cnt_o(ref_cnt),
      .ref_gap_o(ref_gap), .timing_bad_o(timing_bad));
   // pin watch
   always @(negedge clk_i) begin
      if (ck_n !== ~ck_p) wire_bad <= 1'b1;
      if (dq_oe === 1'b1 && (lo_oe & hi_oe) !== 1'b1) wire_bad <= 1'b1;
      if (hi_oe === 1'b1 && hi_o !== lo_o) wire_bad <= 1'b1;
   end
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic complete_run();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : complete_run
   task automatic hang();
      err_count++;
      complete_run();
   endtask : hang
   task automatic do_req(input logic w, input logic [1:0] b, input logic [11:0] r,
         input logic [8:0] c, input logic [63:0] d, input logic [7:0] m);
      int n;
      @(negedge clk_i);
      wr = w;
      bank = b;
      row = r;
      col = c;
      wdata = d;
      wmask = m;
      valid = 1'b1;
      for (n = 0; n < 4000 && ready !== 1'b1; n++) @(negedge clk_i);
      if (n == 4000) hang();
      @(negedge clk_i);
      valid = 1'b0;
   endtask : do_req
   task automatic do_read(input logic [1:0] b, input logic [11:0] r, input logic [8:0] c,
         output logic [63:0] d, output logic e);
      int n;
      do_req(1'b0, b, r, c, 64'h0, 8'h00);
      for (n = 0; n < 150 && rd_valid !== 1'b1; n++) @(negedge clk_i);
      if (n == 150) hang();
      d = rd_data;
      e = rd_err;
   endtask : do_read
   task automatic t_reset_state();
      @(negedge clk_i);
      check("reset pins", {cke, cs_n, ras_n, cas_n, we_n, ck_p, ck_n}, 7'h1D);
   endtask : t_reset_state
   task automatic t_init();
      int n;
      for (n = 0; n < 2000 && init_done !== 1'b1; n++) @(negedge clk_i);
      if (n == 2000) hang();
      check("mode", mode, {6'h00, 3'd3, 1'b0, 3'd2});
      check("init refresh", ref_cnt >= 2, 1);
   endtask : t_init
   task automatic t_mask();
      logic [63:0] d;
      logic e;
      do_req(1'b1, 2'h1, 12'h123, 9'h040, 64'h0123_4567_89AB_CDEF, 8'h00);
      do_req(1'b1, 2'h1, 12'h123, 9'h040, 64'hFEDC_BA98_7654_3210, 8'h96);
      do_read(2'h1, 12'h123, 9'h040, d, e);
      check("masked burst", d, 64'h01DC_BA67_76AB_CD10);
      check("masked err", e, 0);
   endtask : t_mask
   task automatic t_banks();
      logic [63:0] d;
      logic e;
      for (int b = 0; b < 4; b++) begin
         do_req(1'b1, b[1:0], 12'hFFF, 9'h1FC, 64'h1111_2222_3333_4444 * (b + 1), 8'h00);
      end
      for (int b = 3; b >= 0; b--) begin
         do_read(b[1:0], 12'hFFF, 9'h1FC, d, e);
         check("bank burst", d, 64'h1111_2222_3333_4444 * (b + 1));
      end
   endtask : t_banks
   task automatic t_slow();
      logic [63:0] d;
      logic e;
      slow = 1'b1;
      do_read(2'h2, 12'hFFF, 9'h1FC, d, e);
      slow = 1'b0;
      check("slow burst", d, 64'h3333_6666_9999_CCCC);
   endtask : t_slow
   task automatic t_timeout();
      logic [63:0] d;
      logic e;
      mute = 1'b1;
      do_read(2'h0, 12'h000, 9'h000, d, e);
      mute = 1'b0;
      check("silent read err", e, 1);
   endtask : t_timeout
   task automatic t_refresh();
      int n0;
      n0 = ref_cnt;
      repeat (7000) @(negedge clk_i);
      check("refresh count", ref_cnt - n0 >= 2, 1);
      check("refresh gap", ref_gap <= 15625, 1);
   endtask : t_refresh
   initial begin
      t_reset_state();
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      rst_i = 1'b0;
      t_init();
      t_mask();
      t_banks();
      t_slow();
      t_timeout();
      t_refresh();
      check("pin rules", wire_bad, 0);
      check("timing", timing_bad, 0);
      complete_run();
   end
endmodule : mdp_mem_port_tb
`default_nettype wire
